// ===== pmsr_pkg.sv
// pmsr_pkg: map constants, bit-behaviour masks and frame layout of the register bank
package pmsr_pkg;

  // ------------------------------------------------------------
  // geometry and serial frame layout
  // ------------------------------------------------------------
  localparam int REG_W = 24;
  localparam int REG_N = 64;
  localparam int ADDR_W = 6;
  localparam int FRAME_BITS = 32;
  localparam int FRM_WRITE_BIT = 31;
  localparam int FRM_ADDR_MSB = 30;
  localparam int FRM_ADDR_LSB = 25;
  localparam int FRM_DATA_MSB = 23;
  localparam logic [4:0] FRM_LAST_BIT = 5'h1f;
  localparam logic [4:0] FRM_FIRST_DATA = 5'h08;
  localparam int ADC_HALF_W = 10;

  // ------------------------------------------------------------
  // register offsets (register numbers)
  // ------------------------------------------------------------
  localparam logic [5:0] ADDR_IRQ_STATUS = 6'h00;
  localparam logic [5:0] ADDR_IRQ_MASK = 6'h01;
  localparam logic [5:0] ADDR_SENSE = 6'h02;
  localparam logic [5:0] ADDR_UNUSED_A = 6'h23;
  localparam logic [5:0] ADDR_UNUSED_B = 6'h2a;
  localparam logic [5:0] ADDR_ADC_CONTROL_0 = 6'h2b;
  localparam logic [5:0] ADDR_ADC_CONTROL_1 = 6'h2c;
  localparam logic [5:0] ADDR_ADC_RESULT_PRIMARY = 6'h2d;
  localparam logic [5:0] ADDR_ADC_CONTROL_3 = 6'h2e;
  localparam logic [5:0] ADDR_ADC_RESULT_SECONDARY = 6'h2f;
  localparam logic [5:0] ADDR_CHARGER_CONTROL_0 = 6'h30;
  localparam logic [5:0] ADDR_USB_CONTROL_0 = 6'h31;
  localparam logic [5:0] ADDR_CHARGER_USB_CONTROL = 6'h32;
  localparam logic [5:0] ADDR_LED_CONTROL_0 = 6'h33;
  localparam logic [5:0] ADDR_LED_CONTROL_1 = 6'h34;
  localparam logic [5:0] ADDR_LED_CONTROL_2 = 6'h35;
  localparam logic [5:0] ADDR_LED_CONTROL_3 = 6'h36;
  localparam logic [5:0] ADDR_UNUSED_C = 6'h37;
  localparam logic [5:0] ADDR_UNUSED_D = 6'h38;

  // ------------------------------------------------------------
  // field masks and reset values
  // ------------------------------------------------------------
  localparam logic [23:0] MASK_ALL = 24'hffffff;
  localparam logic [23:0] MASK_NONE = 24'h000000;
  localparam logic [23:0] IRQ_IMPL = 24'h397fff;
  localparam logic [23:0] IRQ_OFF_GRP = 24'h011048;
  localparam logic [23:0] IRQ_RTC_GRP = 24'h0000a0;
  localparam logic [23:0] IRQ_MASK_RESET = 24'h397fff;
  localparam logic [23:0] SENSE_IMPL = 24'h197ff8;
  localparam logic [23:0] ADC0_IMPL = 24'hffedff;
  localparam logic [23:0] ADC0_WO = 24'h000200;
  localparam int ADC0_WO_POS = 9;
  localparam logic [23:0] ADC1_RWM = 24'h000001;
  localparam logic [23:0] ADC_RES_HW = 24'hffcffc;
  localparam logic [23:0] ADC3_IMPL = 24'h0001c0;
  localparam logic [23:0] USB0_IMPL = 24'h400080;
  localparam logic [23:0] CHGUSB_IMPL = 24'h030a09;
  localparam logic [23:0] LED_ODD_IMPL = 24'h007fff;

  // storage present behind each bit
  function automatic logic [23:0] f_impl(input logic [5:0] a);
    case (a)
      ADDR_IRQ_STATUS, ADDR_IRQ_MASK: f_impl = IRQ_IMPL;
      ADDR_SENSE, ADDR_UNUSED_A, ADDR_UNUSED_B, ADDR_UNUSED_C, ADDR_UNUSED_D: f_impl = MASK_NONE;
      ADDR_ADC_CONTROL_0: f_impl = ADC0_IMPL;
      ADDR_ADC_CONTROL_3: f_impl = ADC3_IMPL;
      ADDR_USB_CONTROL_0: f_impl = USB0_IMPL;
      ADDR_CHARGER_USB_CONTROL: f_impl = CHGUSB_IMPL;
      ADDR_LED_CONTROL_1, ADDR_LED_CONTROL_3: f_impl = LED_ODD_IMPL;
      default: f_impl = MASK_ALL;
    endcase
  endfunction : f_impl

  // bits that take the written value
  function automatic logic [23:0] f_wr(input logic [5:0] a);
    case (a)
      ADDR_IRQ_STATUS, ADDR_ADC_RESULT_PRIMARY, ADDR_ADC_RESULT_SECONDARY: f_wr = MASK_NONE;
      default: f_wr = f_impl(a);
    endcase
  endfunction : f_wr

  function automatic logic [23:0] f_w1c(input logic [5:0] a);
    f_w1c = (a == ADDR_IRQ_STATUS) ? IRQ_IMPL : MASK_NONE;
  endfunction : f_w1c

  function automatic logic [23:0] f_hw(input logic [5:0] a);
    f_hw = (a == ADDR_ADC_RESULT_PRIMARY || a == ADDR_ADC_RESULT_SECONDARY) ? ADC_RES_HW : MASK_NONE;
  endfunction : f_hw

  function automatic logic [23:0] f_rwm(input logic [5:0] a);
    f_rwm = (a == ADDR_ADC_CONTROL_1) ? ADC1_RWM : MASK_NONE;
  endfunction : f_rwm

  function automatic logic [23:0] f_rst_rtc(input logic [5:0] a);
    f_rst_rtc = (a == ADDR_IRQ_STATUS || a == ADDR_IRQ_MASK) ? IRQ_RTC_GRP : MASK_NONE;
  endfunction : f_rst_rtc

  function automatic logic [23:0] f_rst_off(input logic [5:0] a);
    f_rst_off = (a == ADDR_IRQ_STATUS || a == ADDR_IRQ_MASK) ? IRQ_OFF_GRP : MASK_NONE;
  endfunction : f_rst_off

  function automatic logic [23:0] f_rst_ext(input logic [5:0] a);
    f_rst_ext = f_impl(a) & ~(f_rst_rtc(a) | f_rst_off(a));
  endfunction : f_rst_ext

  function automatic logic [23:0] f_dflt(input logic [5:0] a);
    f_dflt = (a == ADDR_IRQ_MASK) ? IRQ_MASK_RESET : MASK_NONE;
  endfunction : f_dflt

endpackage : pmsr_pkg

// ===== pmsr_store_if.sv
// pmsr_store_if: next/current words and read port between bank logic and storage
`timescale 1ns/1ps
interface pmsr_store_if #(
  parameter int DEPTH = 64,
  parameter int WIDTH = 24,
  parameter int AW = 6
);
  logic [WIDTH-1:0] word_d [DEPTH];
  logic [WIDTH-1:0] word_q [DEPTH];
  logic [AW-1:0] rd_addr;
  logic [WIDTH-1:0] rd_data;

  modport ctrl (output word_d, output rd_addr, input word_q, input rd_data);
  modport store (input word_d, input rd_addr, output word_q, output rd_data);
endinterface : pmsr_store_if

// ===== pmsr_regstore.sv
// pmsr_regstore: word storage of the bank with a registered read port
`timescale 1ns/1ps
module pmsr_regstore #(
  parameter int DEPTH = 64,
  parameter int WIDTH = 24
) (
  // clock
  input wire logic i_core_clk,
  // storage port
  pmsr_store_if.store st
);

  // ------------------------------------------------------------
  // words: next value always computed outside, so no enable here
  // ------------------------------------------------------------
  for (genvar gi = 0; gi < DEPTH; gi++) begin : g_word
    always_ff @(posedge i_core_clk) begin
      st.word_q[gi] <= st.word_d[gi];
    end
  end

  // ------------------------------------------------------------
  // read port: old contents, sampled before the same-edge write
  // ------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    st.rd_data <= st.word_q[st.rd_addr];
  end

endmodule : pmsr_regstore

// ===== pmsr_reg_map.sv
// pmsr_reg_map: serial-link register bank of the power-management device
`timescale 1ns/1ps
module pmsr_reg_map #(
  parameter int REG_N = pmsr_pkg::REG_N,
  parameter int REG_W = pmsr_pkg::REG_W
) (
  // core clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // reset sources, all active low
  input wire logic i_external_reset_n,
  input wire logic i_rtc_power_on_reset_n,
  input wire logic i_off_transition_reset_n,
  // serial link
  input wire logic i_spi_clk,
  input wire logic i_spi_cs_n,
  input wire logic i_spi_mosi,
  output logic o_spi_miso,
  output logic o_spi_miso_oe,
  // device-side events and monitors
  input wire logic [23:0] i_event,
  input wire logic [23:0] i_sense,
  input wire logic i_adc_load_primary,
  input wire logic i_adc_load_secondary,
  input wire logic [19:0] i_adc_value,
  input wire logic i_adc_oneshot_done,
  // register contents and the converter restart strobe steering the device
  output logic [23:0] o_irq_status,
  output logic [23:0] o_irq_mask,
  output logic [23:0] o_adc_ctrl0,
  output logic [23:0] o_adc_ctrl1,
  output logic [23:0] o_adc_ctrl3,
  output logic [23:0] o_charger_ctrl0,
  output logic [23:0] o_usb_ctrl0,
  output logic [23:0] o_charger_usb_ctrl,
  output logic [23:0] o_led_ctrl0,
  output logic [23:0] o_led_ctrl1,
  output logic [23:0] o_led_ctrl2,
  output logic o_adc_reset
);

  // ------------------------------------------------------------
  // link domain: frame shifter
  // ------------------------------------------------------------
  // link clock only runs inside frames, so chip select clears the
  // counter asynchronously instead of waiting for an edge
  logic [4:0] bit_cnt_q;
  logic [30:0] rx_sh_q;
  logic [31:0] frame_q;
  logic frame_tog_q;
  logic tx_bit_q;
  logic [23:0] rsp_q;

  always_ff @(posedge i_spi_clk or posedge i_spi_cs_n) begin
    if (i_spi_cs_n) begin
      bit_cnt_q <= 5'h00;
      rx_sh_q <= 31'h00000000;
    end else begin
      bit_cnt_q <= bit_cnt_q + 5'h01;
      rx_sh_q <= {rx_sh_q[29:0], i_spi_mosi};
    end
  end

  // whole frame held until the next frame completes
  always_ff @(posedge i_spi_clk) begin
    if (!i_spi_cs_n && bit_cnt_q == pmsr_pkg::FRM_LAST_BIT) begin
      frame_q <= {rx_sh_q, i_spi_mosi};
    end
  end

  // event toggle towards the core; cleared by system reset since the
  // link clock may be stopped while reset is applied
  always_ff @(posedge i_spi_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      frame_tog_q <= 1'b0;
    end else if (!i_spi_cs_n && bit_cnt_q == pmsr_pkg::FRM_LAST_BIT) begin
      frame_tog_q <= ~frame_tog_q;
    end
  end

  // answer shifted out on the falling edge; header bits read zero
  always_ff @(negedge i_spi_clk or posedge i_spi_cs_n) begin
    if (i_spi_cs_n) begin
      tx_bit_q <= 1'b0;
    end else if (bit_cnt_q >= pmsr_pkg::FRM_FIRST_DATA) begin
      tx_bit_q <= rsp_q[pmsr_pkg::FRM_LAST_BIT - bit_cnt_q];
    end else begin
      tx_bit_q <= 1'b0;
    end
  end

  assign o_spi_miso = tx_bit_q;
  assign o_spi_miso_oe = ~i_spi_cs_n;

  // ------------------------------------------------------------
  // core domain: synchronisers
  // ------------------------------------------------------------
  logic tog_s1_q;
  logic tog_s2_q;
  logic tog_seen_q;
  logic [2:0] rst_s1_q;
  logic [2:0] rst_s2_q;
  logic [23:0] sense_s1_q;
  logic [23:0] sense_s2_q;

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      tog_s1_q <= 1'b0;
      tog_s2_q <= 1'b0;
    end else begin
      tog_s1_q <= frame_tog_q;
      tog_s2_q <= tog_s1_q;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      tog_seen_q <= 1'b0;
    end else begin
      tog_seen_q <= tog_s2_q;
    end
  end

  // reset pins: held (zero) until two edges after release
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      rst_s1_q <= 3'h0;
      rst_s2_q <= 3'h0;
    end else begin
      rst_s1_q <= {i_off_transition_reset_n, i_rtc_power_on_reset_n, i_external_reset_n};
      rst_s2_q <= rst_s1_q;
    end
  end

  // sense inputs: live copies, two flops of latency only
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      sense_s1_q <= 24'h000000;
      sense_s2_q <= 24'h000000;
    end else begin
      sense_s1_q <= i_sense;
      sense_s2_q <= sense_s1_q;
    end
  end

  // ------------------------------------------------------------
  // core domain: access pipeline
  // ------------------------------------------------------------
  logic frame_evt;
  logic [31:0] cmd_q;
  logic stage1_q;
  logic stage2_q;
  logic cmd_write;
  logic [5:0] cmd_addr;
  logic [23:0] cmd_data;
  logic wr_hit;

  assign frame_evt = tog_s2_q ^ tog_seen_q;
  assign cmd_write = cmd_q[pmsr_pkg::FRM_WRITE_BIT];
  assign cmd_addr = cmd_q[pmsr_pkg::FRM_ADDR_MSB:pmsr_pkg::FRM_ADDR_LSB];
  assign cmd_data = cmd_q[pmsr_pkg::FRM_DATA_MSB:0];
  assign wr_hit = stage1_q && cmd_write;

  // frame word is stable in the link domain for a whole frame time
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      cmd_q <= 32'h00000000;
    end else if (frame_evt) begin
      cmd_q <= frame_q;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      stage1_q <= 1'b0;
      stage2_q <= 1'b0;
    end else begin
      stage1_q <= frame_evt;
      stage2_q <= stage1_q;
    end
  end

  // ------------------------------------------------------------
  // storage and per-bit behaviour
  // ------------------------------------------------------------
  pmsr_store_if #(.DEPTH(REG_N), .WIDTH(REG_W), .AW(pmsr_pkg::ADDR_W)) st ();

  pmsr_regstore #(.DEPTH(REG_N), .WIDTH(REG_W)) u_store (
    .i_core_clk(i_core_clk),
    .st(st.store)
  );

  assign st.rd_addr = cmd_addr;

  logic ext_hold;
  logic rtc_hold;
  logic off_hold;
  logic [23:0] adc_hw_val;

  assign ext_hold = i_sys_rst | ~rst_s2_q[0];
  assign rtc_hold = i_sys_rst | ~rst_s2_q[1];
  assign off_hold = i_sys_rst | ~rst_s2_q[2];
  assign adc_hw_val = {i_adc_value[19:10], 2'b00, i_adc_value[9:0], 2'b00};

  for (genvar gi = 0; gi < REG_N; gi++) begin : g_bank
    localparam logic [5:0] A = 6'(gi);
    logic [23:0] grp;
    logic [23:0] d;
    logic ld;

    always_comb begin
      ld = (A == pmsr_pkg::ADDR_ADC_RESULT_PRIMARY && i_adc_load_primary) ||
           (A == pmsr_pkg::ADDR_ADC_RESULT_SECONDARY && i_adc_load_secondary);
      grp = (ext_hold ? pmsr_pkg::f_rst_ext(A) : 24'h000000) |
            (rtc_hold ? pmsr_pkg::f_rst_rtc(A) : 24'h000000) |
            (off_hold ? pmsr_pkg::f_rst_off(A) : 24'h000000);
      d = st.word_q[gi];
      if (wr_hit && cmd_addr == A) begin
        // read-only bits fall outside the write mask
        d = (d & ~pmsr_pkg::f_wr(A)) | (cmd_data & pmsr_pkg::f_wr(A));
        d = d & ~(cmd_data & pmsr_pkg::f_w1c(A));
      end
      if (ld) begin
        d = (d & ~pmsr_pkg::f_hw(A)) | (adc_hw_val & pmsr_pkg::f_hw(A));
      end
      if (i_adc_oneshot_done) begin
        d = d & ~pmsr_pkg::f_rwm(A);
      end
      // set after clear: an event in the clearing cycle survives
      d = d | (i_event & pmsr_pkg::f_w1c(A));
      // held groups win over every access
      d = (d & ~grp) | (pmsr_pkg::f_dflt(A) & grp);
      // spare bits stay in the mask; unused and reserved never store
      st.word_d[gi] = d & pmsr_pkg::f_impl(A);
    end
  end

  // ------------------------------------------------------------
  // write-only strobe
  // ------------------------------------------------------------
  // converter restart has no storage: one core cycle pulse per write with bit 9 set
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_adc_reset <= 1'b0;
    end else begin
      o_adc_reset <= wr_hit && cmd_addr == pmsr_pkg::ADDR_ADC_CONTROL_0 &&
                     cmd_data[pmsr_pkg::ADC0_WO_POS];
    end
  end

  // ------------------------------------------------------------
  // answer word
  // ------------------------------------------------------------
  // returned in the next frame; the host must leave a gap between
  // frames so this word is settled before the link reads it
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      rsp_q <= 24'h000000;
    end else if (stage2_q) begin
      if (cmd_addr == pmsr_pkg::ADDR_SENSE) begin
        rsp_q <= sense_s2_q & pmsr_pkg::SENSE_IMPL;
      end else begin
        rsp_q <= st.rd_data;
      end
    end
  end

  // ------------------------------------------------------------
  // register contents to the device
  // ------------------------------------------------------------
  assign o_irq_status = st.word_q[pmsr_pkg::ADDR_IRQ_STATUS];
  assign o_irq_mask = st.word_q[pmsr_pkg::ADDR_IRQ_MASK];
  assign o_adc_ctrl0 = st.word_q[pmsr_pkg::ADDR_ADC_CONTROL_0];
  assign o_adc_ctrl1 = st.word_q[pmsr_pkg::ADDR_ADC_CONTROL_1];
  assign o_adc_ctrl3 = st.word_q[pmsr_pkg::ADDR_ADC_CONTROL_3];
  assign o_charger_ctrl0 = st.word_q[pmsr_pkg::ADDR_CHARGER_CONTROL_0];
  assign o_usb_ctrl0 = st.word_q[pmsr_pkg::ADDR_USB_CONTROL_0];
  assign o_charger_usb_ctrl = st.word_q[pmsr_pkg::ADDR_CHARGER_USB_CONTROL];
  assign o_led_ctrl0 = st.word_q[pmsr_pkg::ADDR_LED_CONTROL_0];
  assign o_led_ctrl1 = st.word_q[pmsr_pkg::ADDR_LED_CONTROL_1];
  assign o_led_ctrl2 = st.word_q[pmsr_pkg::ADDR_LED_CONTROL_2];

endmodule : pmsr_reg_map

// ===== pmsr_reg_map_props.sv
// pmsr_reg_map_props: concurrent checks on the register bank ports
`timescale 1ns/1ps
module pmsr_reg_map_props (
  // clock, reset, reset sources
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_external_reset_n,
  input wire logic i_rtc_power_on_reset_n,
  input wire logic i_off_transition_reset_n,
  // link and device inputs
  input wire logic i_spi_cs_n,
  input wire logic o_spi_miso_oe,
  input wire logic o_spi_miso,
  input wire logic [23:0] i_event,
  input wire logic i_adc_oneshot_done,
  // register words and converter restart strobe
  input wire logic [23:0] o_irq_status,
  input wire logic [23:0] o_irq_mask,
  input wire logic [23:0] o_adc_ctrl0,
  input wire logic [23:0] o_adc_ctrl1,
  input wire logic [23:0] o_adc_ctrl3,
  input wire logic [23:0] o_led_ctrl0,
  input wire logic o_adc_reset
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  // ----------------------------------------
  // helper: cycles since external reset high
  // ----------------------------------------
  // pin is synced two edges late, so events count only after that
  logic [2:0] ext_hi_q;
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || !i_external_reset_n) begin
      ext_hi_q <= 3'h0;
    end else if (ext_hi_q != 3'h7) begin
      ext_hi_q <= ext_hi_q + 3'h1;
    end
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_ext_hold;
    !i_external_reset_n [*5] |-> o_led_ctrl0 == 24'h000000 && (o_irq_mask & 24'h386f17) == 24'h386f17;
  endproperty
  a_ext_hold: assert property (p_ext_hold) else $error("external group not held");

  property p_rtc_hold;
    !i_rtc_power_on_reset_n [*5] |-> (o_irq_mask & 24'h0000a0) == 24'h0000a0 && (o_irq_status & 24'h0000a0) == 24'h0;
  endproperty
  a_rtc_hold: assert property (p_rtc_hold) else $error("rtc group not held");

  property p_off_hold;
    !i_off_transition_reset_n [*5] |-> (o_irq_mask & 24'h011048) == 24'h011048 && (o_irq_status & 24'h011048) == 24'h0;
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("off group not held");

  property p_event_set;
    i_event[1] && ext_hi_q >= 3'h4 |=> o_irq_status[1];
  endproperty
  a_event_set: assert property (p_event_set) else $error("event flag not set");

  property p_no_self_set;
    (o_irq_status & ~$past(o_irq_status) & ~$past(i_event)) == 24'h0;
  endproperty
  a_no_self_set: assert property (p_no_self_set) else $error("flag set without event");

  property p_unimpl_zero;
    ((o_irq_status | o_irq_mask) & 24'hc68000) == 24'h0 && (o_adc_ctrl0 & 24'h001200) == 24'h0
      && (o_adc_ctrl3 & 24'hfffe3f) == 24'h0;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("absent bit holds one");

  property p_adc_rst_pulse;
    o_adc_reset |=> !o_adc_reset;
  endproperty
  a_adc_rst_pulse: assert property (p_adc_rst_pulse) else $error("converter reset too long");

  property p_oneshot_clear;
    i_adc_oneshot_done |=> !o_adc_ctrl1[0];
  endproperty
  a_oneshot_clear: assert property (p_oneshot_clear) else $error("modifiable bit not cleared");

  property p_miso_oe;
    o_spi_miso_oe == !i_spi_cs_n && (!i_spi_cs_n || !o_spi_miso);
  endproperty
  a_miso_oe: assert property (p_miso_oe) else $error("answer enable or idle level wrong");

  property p_reset_dflt;
    $fell(i_sys_rst) |-> o_irq_mask == 24'h397fff && o_led_ctrl0 == 24'h0 && !o_adc_reset;
  endproperty
  a_reset_dflt: assert property (p_reset_dflt) else $error("defaults missing");
endmodule : pmsr_reg_map_props

// ===== pmsr_host_model.sv
// pmsr_host_model: link host sending 32-bit frames, clock stopped between frames
`timescale 1ns/1ps
module pmsr_host_model (
  // link pins
  output logic o_spi_clk,
  output logic o_spi_cs_n,
  output logic o_spi_mosi,
  input wire logic i_spi_miso
);
  localparam int HALF = 15;
  initial begin
    o_spi_clk = 1'b0;
    o_spi_cs_n = 1'b1;
    o_spi_mosi = 1'b1;
  end
  // answer word of this frame is the read of the previous one
  task automatic xfer(input logic wr, input logic [5:0] num, input logic [23:0] data, output logic [23:0] rsp);
    logic [31:0] frm;
    frm = {wr, num, 1'b0, data};
    rsp = 24'h0;
    #HALF;
    o_spi_cs_n = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      o_spi_mosi = frm[i];
      #HALF;
      o_spi_clk = 1'b1;
      rsp = {rsp[22:0], i_spi_miso};
      #HALF;
      o_spi_clk = 1'b0;
    end
    #HALF;
    o_spi_cs_n = 1'b1;
    // released line must not keep the last bit
    o_spi_mosi = ~o_spi_mosi;
    #300;
  endtask : xfer
endmodule : pmsr_host_model

// ===== tb_pmsr_reg_map.sv
// tb_pmsr_reg_map: register bank bench, accesses through the link host model
`timescale 1ns/1ps
module tb_pmsr_reg_map;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ext_n = 1'b1, rtc_n = 1'b1, off_n = 1'b1;
  logic spi_clk, spi_cs_n, spi_mosi, spi_miso, miso_oe, adc_rst;
  logic [23:0] ev = 24'h0, sense = 24'h0;
  logic load_p = 1'b0, load_s = 1'b0, done1 = 1'b0;
  logic [19:0] adc_val = 20'h0;
  logic [23:0] w_st, w_mk, w_a0, w_a1, w_a3, w_c0, w_u0, w_cu, w_l0, w_l1, w_l2;
  int err_count = 0, total_checks = 0, cyc = 0, rst_pulses = 0;
  logic [5:0] t_a [12] = '{6'h33, 6'h2e, 6'h31, 6'h32, 6'h34, 6'h2b, 6'h23, 6'h2d, 6'h01, 6'h30, 6'h35, 6'h3f};
  logic [23:0] t_e [12] = '{24'hffffff, 24'h0001c0, 24'h400080, 24'h030a09, 24'h007fff, 24'hffedff,
                            24'h000000, 24'h000000, 24'h397fff, 24'hffffff, 24'hffffff, 24'hffffff};

  always #10 core_clk = ~core_clk;

  pmsr_reg_map i_pmsr_reg_map (.i_core_clk(core_clk), .i_sys_rst(sys_rst),
    .i_external_reset_n(ext_n), .i_rtc_power_on_reset_n(rtc_n), .i_off_transition_reset_n(off_n),
    .i_spi_clk(spi_clk), .i_spi_cs_n(spi_cs_n), .i_spi_mosi(spi_mosi), .o_spi_miso(spi_miso),
    .o_spi_miso_oe(miso_oe), .i_event(ev), .i_sense(sense), .i_adc_load_primary(load_p),
    .i_adc_load_secondary(load_s), .i_adc_value(adc_val), .i_adc_oneshot_done(done1),
    .o_irq_status(w_st), .o_irq_mask(w_mk), .o_adc_ctrl0(w_a0), .o_adc_ctrl1(w_a1), .o_adc_ctrl3(w_a3),
    .o_charger_ctrl0(w_c0), .o_usb_ctrl0(w_u0), .o_charger_usb_ctrl(w_cu), .o_led_ctrl0(w_l0),
    .o_led_ctrl1(w_l1), .o_led_ctrl2(w_l2), .o_adc_reset(adc_rst));

  pmsr_host_model i_pmsr_host_model (.o_spi_clk(spi_clk), .o_spi_cs_n(spi_cs_n), .o_spi_mosi(spi_mosi),
    .i_spi_miso(miso_oe ? spi_miso : 1'b0));

  // ----------------------------------------
  // access, compare, event and reset-pin stimulus, and report tasks
  // ----------------------------------------
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    logic [23:0] r;
    i_pmsr_host_model.xfer(1'b1, a, d, r);
  endtask : wr

  task automatic rchk(input logic [5:0] a, input logic [23:0] exp);
    logic [23:0] r;
    i_pmsr_host_model.xfer(1'b0, a, 24'h0, r);
    i_pmsr_host_model.xfer(1'b0, a, 24'h0, r);
    chk(r, exp);
  endtask : rchk

  task automatic pulse(input logic [23:0] v);
    @(negedge core_clk);
    ev = v;
    @(negedge core_clk);
    ev = 24'h0;
  endtask : pulse

  task automatic hold(input int k);
    @(negedge core_clk);
    {rtc_n, off_n} = k ? 2'h1 : 2'h2;
    repeat (8) @(negedge core_clk);
    {rtc_n, off_n} = 2'h3;
    repeat (4) @(negedge core_clk);
  endtask : hold

  // pulse stands one cycle, so count it mid-cycle; hang guard too
  always @(negedge core_clk) begin
    cyc++;
    if (adc_rst === 1'b1) begin
      rst_pulses++;
    end
    if (cyc == 30000) begin
      err_count++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (16) @(negedge core_clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge core_clk);
    rchk(6'h01, 24'h397fff);
    rchk(6'h33, 24'h000000);
    $display("test defaults done");
    foreach (t_a[i]) begin
      wr(t_a[i], 24'hffffff);
      rchk(t_a[i], t_e[i]);
      // word outputs must follow what the read returned
      case (t_a[i])
        6'h01: chk(w_mk, t_e[i]);
        6'h2b: chk(w_a0, t_e[i]);
        6'h2e: chk(w_a3, t_e[i]);
        6'h30: chk(w_c0, t_e[i]);
        6'h31: chk(w_u0, t_e[i]);
        6'h32: chk(w_cu, t_e[i]);
        6'h33: chk(w_l0, t_e[i]);
        6'h34: chk(w_l1, t_e[i]);
        6'h35: chk(w_l2, t_e[i]);
        default: ;
      endcase
      wr(t_a[i], 24'h000000);
      rchk(t_a[i], 24'h000000);
    end
    chk(24'(rst_pulses), 24'h000001);
    $display("test access done");
    pulse(24'h008003);
    rchk(6'h00, 24'h000003);
    wr(6'h00, 24'h000001);
    rchk(6'h00, 24'h000002);
    wr(6'h00, 24'h000000);
    rchk(6'h00, 24'h000002);
    chk(w_st, 24'h000002);
    wr(6'h00, 24'h000002);
    wr(6'h2c, 24'h000001);
    rchk(6'h2c, 24'h000001);
    @(negedge core_clk);
    done1 = 1'b1;
    @(negedge core_clk);
    done1 = 1'b0;
    rchk(6'h2c, 24'h000000);
    $display("test flags done");
    for (int k = 0; k < 2; k++) begin
      @(negedge core_clk);
      adc_val = k ? 20'h5aa65 : 20'ha955a;
      load_p = (k == 0);
      load_s = (k == 1);
      @(negedge core_clk);
      load_p = 1'b0;
      load_s = 1'b0;
      rchk(k ? 6'h2f : 6'h2d, {adc_val[19:10], 2'h0, adc_val[9:0], 2'h0});
    end
    rchk(6'h2d, 24'ha94568);
    @(negedge core_clk);
    sense = 24'hffffff;
    rchk(6'h02, 24'h197ff8);
    @(negedge core_clk);
    sense = 24'h000000;
    rchk(6'h02, 24'h000000);
    $display("test results done");
    pulse(24'h0110e9);
    hold(0);
    rchk(6'h01, 24'h011048);
    rchk(6'h00, 24'h0000a1);
    hold(1);
    rchk(6'h01, 24'h0110e8);
    rchk(6'h00, 24'h000001);
    @(negedge core_clk);
    ext_n = 1'b0;
    wr(6'h33, 24'habcdef);
    @(negedge core_clk);
    ext_n = 1'b1;
    repeat (4) @(negedge core_clk);
    rchk(6'h01, 24'h397fff);
    rchk(6'h00, 24'h000000);
    rchk(6'h33, 24'h000000);
    wr(6'h35, 24'h0000aa);
    @(negedge core_clk);
    // the write must have landed, or the reset check below proves nothing
    chk(w_l2, 24'h0000aa);
    sys_rst = 1'b1;
    repeat (16) @(negedge core_clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge core_clk);
    rchk(6'h35, 24'h000000);
    $display("test resets done");
    report_and_stop();
  end
endmodule : tb_pmsr_reg_map

bind pmsr_reg_map pmsr_reg_map_props i_pmsr_reg_map_props (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
  .i_external_reset_n(i_external_reset_n), .i_rtc_power_on_reset_n(i_rtc_power_on_reset_n),
  .i_off_transition_reset_n(i_off_transition_reset_n), .i_spi_cs_n(i_spi_cs_n), .o_spi_miso_oe(o_spi_miso_oe),
  .i_event(i_event), .i_adc_oneshot_done(i_adc_oneshot_done), .o_irq_status(o_irq_status),
  .o_irq_mask(o_irq_mask), .o_adc_ctrl0(o_adc_ctrl0), .o_adc_ctrl1(o_adc_ctrl1), .o_adc_ctrl3(o_adc_ctrl3),
  .o_led_ctrl0(o_led_ctrl0), .o_adc_reset(o_adc_reset), .o_spi_miso(o_spi_miso));
